// ==== rtl/config_set_manager.sv ====
// configuration set manager with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module config_set_manager
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclk_en,
    input wire logic acq_active,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [7:0] gain,
    output logic [1:0] expo_auto,
    output logic busy
);
    typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_COPY} phase_t;
    typedef struct packed {
        phase_t phase;
        logic [3:0] cnt;
        logic store_dir;
        logic [7:0] gain;
        logic [1:0] expo;
        logic [7:0] lut;
        logic [1:0] slot_choice;
        logic reject;
        logic aw_ok;
        logic w_ok;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic acq_s1;
        logic acq_s2;
        logic busy;
    } state_t;
    state_t s;
    state_t next_s;
    logic nv_wr;
    logic nv_cfg_wr;
    logic [1:0] nv_rd_slot;
    logic [9:0] nv_rd_data;
    logic [1:0] nv_baseline;
    logic [1:0] nv_boot;
    logic [1:0] next_baseline;
    logic [1:0] next_boot;
    logic do_write;
    logic [31:0] wmask;

    // fixed factory images, gain then exposure mode
    function automatic logic [9:0] factory_image(input logic [1:0] sel);
        logic [9:0] img;
        img = {cfg_set_pkg::GAIN_LOW, cfg_set_pkg::EXPO_OFF};
        unique case (sel)
            cfg_set_pkg::FAC_STANDARD: img = {cfg_set_pkg::GAIN_LOW, cfg_set_pkg::EXPO_OFF};
            cfg_set_pkg::FAC_HIGH_GAIN: img = {cfg_set_pkg::GAIN_PLUS6, cfg_set_pkg::EXPO_OFF};
            cfg_set_pkg::FAC_AUTO: img = {cfg_set_pkg::GAIN_LOW, cfg_set_pkg::EXPO_CONT};
            cfg_set_pkg::FAC_COLOUR: img = {cfg_set_pkg::GAIN_COLOUR, cfg_set_pkg::EXPO_OFF};
        endcase
        return img;
    endfunction

    // baseline and user slots in non-volatile store
    cfg_nv_store u_nv
    (
        .aclk(aclk),
        .aclk_en(aclk_en),
        .wr_en(nv_wr),
        .wr_slot(s.slot_choice),
        .wr_data({s.gain, s.expo}),
        .rd_slot(nv_rd_slot),
        .rd_data(nv_rd_data),
        .cfg_wr(nv_cfg_wr),
        .baseline_in(next_baseline),
        .boot_in(next_boot),
        .baseline(nv_baseline),
        .boot(nv_boot)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_s = s;
        nv_wr = 1'b0;
        nv_cfg_wr = 1'b0;
        next_baseline = nv_baseline;
        next_boot = nv_boot;
        nv_rd_slot = s.slot_choice;
        do_write = 1'b0;
        wmask = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
        next_s.acq_s1 = acq_active;
        next_s.acq_s2 = s.acq_s1;
        // write channels accepted in either order
        if (s_axi_awvalid && !s.aw_ok && !s.bvalid)
        begin
            next_s.aw_ok = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.w_ok && !s.bvalid)
        begin
            next_s.w_ok = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready)
            next_s.bvalid = 1'b0;
        if (s.aw_ok && s.w_ok && !s.bvalid)
        begin
            do_write = 1'b1;
            next_s.aw_ok = 1'b0;
            next_s.w_ok = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = cfg_set_pkg::RESP_OKAY;
            next_s.reject = 1'b0;
        end
        unique case (s.phase)
            ST_BOOT:
            begin
                nv_rd_slot = nv_boot;
                next_s.phase = ST_IDLE;
                if (nv_boot == cfg_set_pkg::SLOT_DEFAULT)
                    {next_s.gain, next_s.expo} = factory_image(nv_baseline);
                else
                    {next_s.gain, next_s.expo} = nv_rd_data;
            end
            ST_COPY:
            begin
                next_s.cnt = s.cnt - 4'h1;
                if (s.cnt == 4'h1)
                begin
                    next_s.phase = ST_IDLE;
                    if (s.store_dir)
                        nv_wr = 1'b1;
                    else if (s.slot_choice == cfg_set_pkg::SLOT_DEFAULT)
                        {next_s.gain, next_s.expo} = factory_image(nv_baseline);
                    else
                        {next_s.gain, next_s.expo} = nv_rd_data;
                end
            end
            ST_IDLE:
            begin
            end
        endcase
        if (do_write)
        begin
            // refuse commands and selections while copying
            if (s.phase != ST_IDLE && s.awaddr >= cfg_set_pkg::OFF_BASELINE
                && s.awaddr <= cfg_set_pkg::OFF_COMMAND)
            begin
                next_s.bresp = cfg_set_pkg::RESP_SLVERR;
                next_s.reject = 1'b1;
            end
            else
            begin
                unique case (s.awaddr)
                    // host writes go to active set
                    cfg_set_pkg::OFF_GAIN: next_s.gain = (s.gain & ~wmask[7:0]) | (s.wdata[7:0] & wmask[7:0]);
                    cfg_set_pkg::OFF_EXPO_AUTO: if (s.wstrb[0]) next_s.expo = s.wdata[1:0];
                    cfg_set_pkg::OFF_LUT: if (s.wstrb[0]) next_s.lut = s.wdata[7:0];
                    cfg_set_pkg::OFF_BASELINE:
                        if (s.acq_s2)
                        begin
                            next_s.bresp = cfg_set_pkg::RESP_SLVERR;
                            next_s.reject = 1'b1;
                        end
                        else if (s.wstrb[0])
                        begin
                            next_baseline = s.wdata[1:0];
                            nv_cfg_wr = 1'b1;
                        end
                    cfg_set_pkg::OFF_SLOT_CHOICE: if (s.wstrb[0]) next_s.slot_choice = s.wdata[1:0];
                    cfg_set_pkg::OFF_BOOT_CHOICE:
                        if (s.wstrb[0])
                        begin
                            next_boot = s.wdata[1:0];
                            nv_cfg_wr = 1'b1;
                        end
                    cfg_set_pkg::OFF_COMMAND:
                        if (s.wstrb[0] && s.wdata[cfg_set_pkg::CMD_STORE_BIT])
                        begin
                            if (s.slot_choice == cfg_set_pkg::SLOT_DEFAULT)
                            begin
                                next_s.bresp = cfg_set_pkg::RESP_SLVERR;
                                next_s.reject = 1'b1;
                            end
                            else
                            begin
                                next_s.phase = ST_COPY;
                                next_s.cnt = cfg_set_pkg::COPY_CYCLES;
                                next_s.store_dir = 1'b1;
                            end
                        end
                        else if (s.wstrb[0] && s.wdata[cfg_set_pkg::CMD_RESTORE_BIT])
                        begin
                            if (s.acq_s2)
                            begin
                                next_s.bresp = cfg_set_pkg::RESP_SLVERR;
                                next_s.reject = 1'b1;
                            end
                            else
                            begin
                                next_s.phase = ST_COPY;
                                next_s.cnt = cfg_set_pkg::COPY_CYCLES;
                                next_s.store_dir = 1'b0;
                            end
                        end
                    cfg_set_pkg::OFF_STATUS:
                    begin
                    end
                    default: next_s.bresp = cfg_set_pkg::RESP_SLVERR;
                endcase
            end
        end
        // read channel
        next_s.arready = 1'b0;
        if (s.rvalid && s_axi_rready)
            next_s.rvalid = 1'b0;
        if (s_axi_arvalid && !s.arready && !s.rvalid)
        begin
            next_s.arready = 1'b1;
            next_s.rvalid = 1'b1;
            next_s.rresp = cfg_set_pkg::RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            unique case (s_axi_araddr)
                cfg_set_pkg::OFF_GAIN: next_s.rdata[7:0] = s.gain;
                cfg_set_pkg::OFF_EXPO_AUTO: next_s.rdata[1:0] = s.expo;
                cfg_set_pkg::OFF_LUT: next_s.rdata[7:0] = s.lut;
                cfg_set_pkg::OFF_BASELINE: next_s.rdata[1:0] = nv_baseline;
                cfg_set_pkg::OFF_SLOT_CHOICE: next_s.rdata[1:0] = s.slot_choice;
                cfg_set_pkg::OFF_BOOT_CHOICE: next_s.rdata[1:0] = nv_boot;
                cfg_set_pkg::OFF_COMMAND:
                begin
                end
                cfg_set_pkg::OFF_STATUS:
                begin
                    next_s.rdata[cfg_set_pkg::STAT_BUSY_BIT] = (s.phase != ST_IDLE);
                    next_s.rdata[cfg_set_pkg::STAT_REJECT_BIT] = s.reject;
                end
                default: next_s.rresp = cfg_set_pkg::RESP_SLVERR;
            endcase
        end
        next_s.busy = (next_s.phase == ST_COPY);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.phase <= ST_BOOT;
        end
        else if (aclk_en)
            s <= next_s;
    end

    assign s_axi_awready = s.aw_ok;
    assign s_axi_wready = s.w_ok;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign gain = s.gain;
    assign expo_auto = s.expo;
    assign busy = s.busy;

    ////////////////////////////////////////////////////////////////////////////
    // busy spans the copy
    a_copy_busy_len: assert property (@(posedge aclk) disable iff (!aresetn)
        (aclk_en && s.phase == ST_IDLE ##1 s.phase == ST_COPY && aclk_en) |-> s.cnt == cfg_set_pkg::COPY_CYCLES)
        else $error("copy count not loaded");
    a_store_no_active: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.phase == ST_COPY && s.store_dir && aclk_en && !do_write) |=> $stable(s.gain))
        else $error("store changed active set");
    a_boot_leaves: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.phase == ST_BOOT && aclk_en) |=> s.phase == ST_IDLE)
        else $error("startup load did not finish");
    a_reject_busy_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
        (aclk_en && do_write && s.phase == ST_COPY && s.awaddr == cfg_set_pkg::OFF_COMMAND)
        |=> s.reject && s.bresp == cfg_set_pkg::RESP_SLVERR)
        else $error("command taken while busy");
    a_baseline_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        (aclk_en && nv_cfg_wr && s.awaddr == cfg_set_pkg::OFF_BASELINE) |-> !s.acq_s2)
        else $error("baseline changed while acquiring");
    a_restore_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        (aclk_en && s.phase == ST_IDLE ##1 s.phase == ST_COPY && !s.store_dir) |-> !$past(s.acq_s2))
        else $error("restore taken while acquiring");
    a_lut_reset: assert property (@(posedge aclk)
        !aresetn |=> s.lut == 8'h00)
        else $error("lookup table survived reset");
    a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        (aclk_en && do_write) |=> s.bvalid)
        else $error("write response missing");
endmodule
`default_nettype wire

// ==== rtl/cfg_set_pkg.sv ====
// constants for the configuration set manager
`default_nettype none
package cfg_set_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_GAIN = 8'h00;
    localparam logic [7:0] OFF_EXPO_AUTO = 8'h04;
    localparam logic [7:0] OFF_LUT = 8'h08;
    localparam logic [7:0] OFF_BASELINE = 8'h0c;
    localparam logic [7:0] OFF_SLOT_CHOICE = 8'h10;
    localparam logic [7:0] OFF_BOOT_CHOICE = 8'h14;
    localparam logic [7:0] OFF_COMMAND = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1c;
    // command bits
    localparam int CMD_STORE_BIT = 0;
    localparam int CMD_RESTORE_BIT = 1;
    // status bits
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_REJECT_BIT = 1;
    // slot codes: 0 default set, 1..3 user slots
    localparam logic [1:0] SLOT_DEFAULT = 2'h0;
    localparam logic [1:0] SLOT_USER1 = 2'h1;
    localparam logic [1:0] SLOT_USER3 = 2'h3;
    // factory setup codes
    localparam logic [1:0] FAC_STANDARD = 2'h0;
    localparam logic [1:0] FAC_HIGH_GAIN = 2'h1;
    localparam logic [1:0] FAC_AUTO = 2'h2;
    localparam logic [1:0] FAC_COLOUR = 2'h3;
    // factory gain values in dB steps and exposure auto modes
    localparam logic [7:0] GAIN_LOW = 8'h00;
    localparam logic [7:0] GAIN_PLUS6 = 8'h06;
    localparam logic [7:0] GAIN_COLOUR = 8'h02;
    localparam logic [1:0] EXPO_OFF = 2'h0;
    localparam logic [1:0] EXPO_CONT = 2'h2;
    // cycles taken by one non-volatile copy
    localparam logic [3:0] COPY_CYCLES = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ==== rtl/cfg_nv_store.sv ====
// non-volatile store for user slots and baseline choices
`timescale 1ns/1ps
`default_nettype none
module cfg_nv_store
(
    input wire logic aclk,
    input wire logic aclk_en,
    input wire logic wr_en,
    input wire logic [1:0] wr_slot,
    input wire logic [9:0] wr_data,
    input wire logic [1:0] rd_slot,
    output logic [9:0] rd_data,
    input wire logic cfg_wr,
    input wire logic [1:0] baseline_in,
    input wire logic [1:0] boot_in,
    output logic [1:0] baseline,
    output logic [1:0] boot
);
    // no reset here, slots survive like flash
    logic [9:0] slot_mem [1:3] = '{10'h000, 10'h000, 10'h000};
    logic [1:0] baseline_q = cfg_set_pkg::FAC_STANDARD;
    logic [1:0] boot_q = cfg_set_pkg::SLOT_DEFAULT;
    always_ff @(posedge aclk)
    begin
        if (aclk_en)
        begin
            if (wr_en && wr_slot != cfg_set_pkg::SLOT_DEFAULT)
                slot_mem[wr_slot] <= wr_data;
            if (cfg_wr)
            begin
                baseline_q <= baseline_in;
                boot_q <= boot_in;
            end
        end
    end
    assign rd_data = (rd_slot == cfg_set_pkg::SLOT_DEFAULT) ? 10'h000 : slot_mem[rd_slot];
    assign baseline = baseline_q;
    assign boot = boot_q;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the configuration set manager
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic aclk;
    logic aresetn;
    logic aclk_en;
    logic [3:0] s_axi_wstrb;
    logic acq_active;
    logic [7:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [7:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic [7:0] gain;
    logic [1:0] expo_auto;
    logic busy;
    int errors = 0;
    int n_checks = 0;
    logic [31:0] rdv;
    logic [1:0] rsp;
    logic [7:0] fac_gain [4];
    logic [1:0] fac_expo [4];

    config_set_manager u_config_set_manager
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .aclk_en(aclk_en),
        .acq_active(acq_active),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .gain(gain),
        .expo_auto(expo_auto),
        .busy(busy)
    );

    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // axi write: address and data together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        r = 2'h3;
        for (k = 0; k < 100; k++)
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
            begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (k == 100)
            errors++;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r = 2'h3;
        d = 'x;
        for (k = 0; k < 100; k++)
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
            begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (k == 100)
            errors++;
    endtask

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
        wr(a, d, rsp);
        check($sformatf("bresp at %h", a), 32'(rsp), 32'(exp));
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        rd(a, rdv, rsp);
        check(name, rdv, exp);
    endtask

    task automatic wait_idle;
        int k;
        for (k = 0; k < 50 && busy !== 1'b0; k++)
            @(posedge aclk);
        repeat (2) @(posedge aclk);
        check("busy clear", 32'(busy), 32'h0);
    endtask

    // copy command: store is bit 0, restore bit 1
    task automatic copy(input logic [1:0] slot, input bit restore);
        wr_chk(cfg_set_pkg::OFF_SLOT_CHOICE, 32'(slot), cfg_set_pkg::RESP_OKAY);
        wr_chk(cfg_set_pkg::OFF_COMMAND, restore ? 32'h2 : 32'h1, cfg_set_pkg::RESP_OKAY);
        wait_idle();
    endtask

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge aclk);
        errors++;
        summarize();
    end

    initial
    begin
        aresetn = 1'b0;
        acq_active = 1'b0;
        aclk_en = 1'b1;
        s_axi_wstrb = 4'hf;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        fac_gain = '{cfg_set_pkg::GAIN_LOW, cfg_set_pkg::GAIN_PLUS6, cfg_set_pkg::GAIN_LOW, cfg_set_pkg::GAIN_COLOUR};
        fac_expo = '{cfg_set_pkg::EXPO_OFF, cfg_set_pkg::EXPO_OFF, cfg_set_pkg::EXPO_CONT, cfg_set_pkg::EXPO_OFF};
        @(posedge aclk);
        do_reset();
        rd_chk("baseline", cfg_set_pkg::OFF_BASELINE, 32'h0);
        check("gain boot", 32'(gain), 32'(cfg_set_pkg::GAIN_LOW));
        check("expo boot", 32'(expo_auto), 32'(cfg_set_pkg::EXPO_OFF));
        wr_chk(cfg_set_pkg::OFF_GAIN, 32'h35, cfg_set_pkg::RESP_OKAY);
        wr_chk(cfg_set_pkg::OFF_EXPO_AUTO, 32'h2, cfg_set_pkg::RESP_OKAY);
        wr_chk(cfg_set_pkg::OFF_LUT, 32'h5a, cfg_set_pkg::RESP_OKAY);
        rd_chk("lut", cfg_set_pkg::OFF_LUT, 32'h5a);
        check("gain port", 32'(gain), 32'h35);
        check("expo port", 32'(expo_auto), 32'h2);
        // a write with no byte strobes leaves gain alone
        s_axi_wstrb <= 4'h0;
        wr_chk(cfg_set_pkg::OFF_GAIN, 32'h77, cfg_set_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        check("gain strobe", 32'(gain), 32'h35);
        // store with the default set chosen is refused
        wr_chk(cfg_set_pkg::OFF_SLOT_CHOICE, 32'h0, cfg_set_pkg::RESP_OKAY);
        wr_chk(cfg_set_pkg::OFF_COMMAND, 32'h1, cfg_set_pkg::RESP_SLVERR);
        rd_chk("reject flag", cfg_set_pkg::OFF_STATUS, 32'h2);
        // baseline and command writes refused during a copy
        wr_chk(cfg_set_pkg::OFF_SLOT_CHOICE, 32'h1, cfg_set_pkg::RESP_OKAY);
        wr_chk(cfg_set_pkg::OFF_COMMAND, 32'h1, cfg_set_pkg::RESP_OKAY);
        wr_chk(cfg_set_pkg::OFF_BASELINE, 32'h1, cfg_set_pkg::RESP_SLVERR);
        check("busy", 32'(busy), 32'h1);
        // a low clock enable freezes the copy
        aclk_en <= 1'b0;
        repeat (20) @(posedge aclk);
        check("busy frozen", 32'(busy), 32'h1);
        aclk_en <= 1'b1;
        wr_chk(cfg_set_pkg::OFF_COMMAND, 32'h2, cfg_set_pkg::RESP_SLVERR);
        wait_idle();
        rd_chk("baseline kept", cfg_set_pkg::OFF_BASELINE, 32'h0);
        // every user slot, slot 1 overwritten
        for (int s = 1; s < 4; s++)
        begin
            wr_chk(cfg_set_pkg::OFF_GAIN, 32'h40 + s, cfg_set_pkg::RESP_OKAY);
            copy(2'(s), 1'b0);
        end
        for (int s = 1; s < 4; s++)
        begin
            wr_chk(cfg_set_pkg::OFF_GAIN, 32'h11, cfg_set_pkg::RESP_OKAY);
            copy(2'(s), 1'b1);
            check("gain restored", 32'(gain), 32'h40 + s);
        end
        // every factory setup through the default set
        for (int f = 0; f < 4; f++)
        begin
            wr_chk(cfg_set_pkg::OFF_BASELINE, 32'(f), cfg_set_pkg::RESP_OKAY);
            rd_chk("baseline", cfg_set_pkg::OFF_BASELINE, 32'(f));
            copy(cfg_set_pkg::SLOT_DEFAULT, 1'b1);
            check("factory gain", 32'(gain), 32'(fac_gain[f]));
            check("factory expo", 32'(expo_auto), 32'(fac_expo[f]));
        end
        wr_chk(cfg_set_pkg::OFF_BASELINE, 32'h1, cfg_set_pkg::RESP_OKAY);
        // acquisition running
        acq_active <= 1'b1;
        repeat (3) @(posedge aclk);
        wr_chk(cfg_set_pkg::OFF_BASELINE, 32'h0, cfg_set_pkg::RESP_SLVERR);
        rd_chk("baseline held", cfg_set_pkg::OFF_BASELINE, 32'h1);
        wr_chk(cfg_set_pkg::OFF_SLOT_CHOICE, 32'h0, cfg_set_pkg::RESP_OKAY);
        wr_chk(cfg_set_pkg::OFF_COMMAND, 32'h2, cfg_set_pkg::RESP_SLVERR);
        check("gain held", 32'(gain), 32'(cfg_set_pkg::GAIN_COLOUR));
        acq_active <= 1'b0;
        repeat (3) @(posedge aclk);
        // startup from user slot 2, then from the default set
        wr_chk(cfg_set_pkg::OFF_BOOT_CHOICE, 32'h2, cfg_set_pkg::RESP_OKAY);
        wr_chk(cfg_set_pkg::OFF_LUT, 32'h5a, cfg_set_pkg::RESP_OKAY);
        do_reset();
        check("startup gain", 32'(gain), 32'h42);
        rd_chk("boot choice", cfg_set_pkg::OFF_BOOT_CHOICE, 32'h2);
        rd_chk("baseline kept", cfg_set_pkg::OFF_BASELINE, 32'h1);
        rd_chk("lut cleared", cfg_set_pkg::OFF_LUT, 32'h0);
        wr_chk(cfg_set_pkg::OFF_BOOT_CHOICE, 32'h0, cfg_set_pkg::RESP_OKAY);
        do_reset();
        check("startup default", 32'(gain), 32'(cfg_set_pkg::GAIN_PLUS6));
        // unmapped address
        wr_chk(8'h20, 32'h0, cfg_set_pkg::RESP_SLVERR);
        rd(8'h20, rdv, rsp);
        check("rresp unmapped", 32'(rsp), 32'(cfg_set_pkg::RESP_SLVERR));
        summarize();
    end
endmodule
`default_nettype wire
